// ==== hw/swp_core.v ====
`timescale 1ns/1ps
`include "swp_map.vh"
module swp_core #(
    parameter TWC_CYC = `SWP_TWC_CYC
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Serial pins
    input wire sck_in,
    input wire cs_n_in,
    input wire si_in,
    input wire wp_n_in,
    output reg so_out,
    output reg so_oe_n_out,
    // Array write port towards the memory
    output reg arr_we_out,
    output reg [11:0] arr_addr_out,
    output reg [7:0] arr_data_out,
    // Status view
    output reg [7:0] status_out
);

localparam ST_CMD = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_WDATA = 3'h2;
localparam ST_READ_STATUS_CMD = 3'h3;
localparam ST_IGN = 3'h4;

wire [3:0] pins_s;
reg sck_d_r;
reg [2:0] st_r;
reg [7:0] sh_r;
reg [2:0] bit_r;
reg [3:0] acnt_r;
reg [15:0] addr_r;
reg [7:0] cmd_r;
reg [7:0] page_r [0:31];
reg [4:0] pcnt_r;
reg [5:0] nbytes_r;
reg wel_r;
reg hpe_r;
reg bphi_r;
reg bplo_r;
reg wip_r;
reg [31:0] twc_r;
reg [4:0] wr_idx_r;
reg [7:0] rd_sh_r;
reg armed_r;
reg [2:0] nv_new_r;
reg wr_is_sr_r;
reg [11:0] wr_base_r;
reg cs_d_r;
integer i;

wire sck_s = pins_s[0];
wire cs_n_s = pins_s[1];
wire si_s = pins_s[2];
wire wp_n_s = pins_s[3];
wire sck_rise = sck_s & ~sck_d_r;
wire sck_fall = ~sck_s & sck_d_r;
wire cs_rise = cs_n_s & ~cs_d_r;
wire [7:0] byte_in = {sh_r[6:0], si_s};

// Block protection decode, used only at launch of an array write
function prot_hit;
    input hi;
    input lo;
    input [11:0] a;
    begin
        case ({hi, lo})
            2'b00: prot_hit = 1'b0;
            2'b01: prot_hit = (a >= `SWP_QTR_BASE);
            2'b10: prot_hit = (a >= `SWP_HALF_BASE);
            default: prot_hit = 1'b1;
        endcase
    end
endfunction

wire hw_prot = ~wp_n_s & hpe_r;
wire [7:0] sr_val = {hpe_r, 3'h0, bphi_r, bplo_r, wel_r, wip_r};
wire [4:0] page_off = addr_r[4:0];

swp_sync #(
    .WIDTH(4),
    .RST_VAL(4'ha)
) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .async_in({wp_n_in, si_in, cs_n_in, sck_in}),
    .sync_out(pins_s)
);

// Edge history of the synchronised pins
always @(posedge sys_clk_in) begin
    if (rst_in) begin
        sck_d_r <= 1'b0;
        cs_d_r <= 1'b1;
    end else begin
        sck_d_r <= sck_s;
        cs_d_r <= cs_n_s;
    end
end

// Serial command decoder; the bit count decides whether select rose on a byte boundary
always @(posedge sys_clk_in) begin
    if (rst_in) begin
        st_r <= ST_CMD;
        sh_r <= 8'h00;
        bit_r <= 3'h0;
        acnt_r <= 4'h0;
        addr_r <= 16'h0000;
        cmd_r <= 8'h00;
        pcnt_r <= 5'h0;
        nbytes_r <= 6'h0;
        rd_sh_r <= 8'h00;
    end else if (cs_n_s) begin
        st_r <= ST_CMD;
        bit_r <= 3'h0;
        acnt_r <= 4'h0;
        nbytes_r <= 6'h0;
        if (!cs_rise) begin
            cmd_r <= 8'h00;
        end
    end else if (sck_rise) begin
        sh_r <= byte_in;
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h7) begin
            case (st_r)
                ST_CMD: begin
                    cmd_r <= byte_in;
                    if (byte_in == `SWP_OP_WRITE && !wip_r) begin
                        st_r <= ST_ADDR;
                    end else if (byte_in == `SWP_OP_RD_STATUS) begin
                        st_r <= ST_READ_STATUS_CMD;
                        rd_sh_r <= sr_val;
                    end else if (byte_in == `SWP_OP_WR_STATUS && !wip_r) begin
                        st_r <= ST_WDATA;
                    end else begin
                        st_r <= ST_IGN;
                    end
                end
                ST_ADDR: begin
                    addr_r <= {addr_r[7:0], byte_in};
                    acnt_r <= acnt_r + 4'h1;
                    if (acnt_r == 4'h1) begin
                        st_r <= ST_WDATA;
                        pcnt_r <= 5'h0;
                    end
                end
                ST_WDATA: begin
                    page_r[page_off + pcnt_r] <= byte_in;
                    pcnt_r <= pcnt_r + 5'h1;
                    if (nbytes_r != 6'h20) begin
                        nbytes_r <= nbytes_r + 6'h1;
                    end
                end
                ST_READ_STATUS_CMD: begin
                    rd_sh_r <= sr_val; // Status repeats per byte
                end
                default: begin
                    st_r <= ST_IGN;
                end
            endcase
        end
    end
end

// Serial output: shifted after falling clock, released when deselected
always @(posedge sys_clk_in) begin
    if (rst_in) begin
        so_out <= 1'b0;
        so_oe_n_out <= 1'b1;
    end else if (cs_n_s || st_r != ST_READ_STATUS_CMD) begin
        so_oe_n_out <= 1'b1;
        so_out <= 1'b0;
    end else if (sck_fall) begin
        so_oe_n_out <= 1'b0;
        so_out <= rd_sh_r[3'h7 - bit_r];
    end
end

// Latch, nonvolatile bits and launch of internal write cycles on select rise
always @(posedge sys_clk_in) begin
    if (rst_in) begin
        wel_r <= 1'b0;
        {hpe_r, bphi_r, bplo_r} <= `SWP_NV_RESET;
        wip_r <= 1'b0;
        twc_r <= 32'h0;
        armed_r <= 1'b0;
        nv_new_r <= 3'h0;
        wr_is_sr_r <= 1'b0;
        wr_base_r <= 12'h000;
        wr_idx_r <= 5'h0;
        arr_we_out <= 1'b0;
        arr_addr_out <= 12'h000;
        arr_data_out <= 8'h00;
    end else begin
        arr_we_out <= 1'b0;
        if (cs_rise && bit_r == 3'h0) begin
            case (cmd_r)
                `SWP_OP_SET_LATCH: begin
                    if (st_r == ST_IGN) begin
                        wel_r <= 1'b1;
                    end
                end
                `SWP_OP_CLR_LATCH: begin
                    if (st_r == ST_IGN) begin
                        wel_r <= 1'b0;
                    end
                end
                `SWP_OP_WR_STATUS: begin
                    if (st_r == ST_WDATA && nbytes_r == 6'h1 && wel_r && !hw_prot) begin
                        wip_r <= 1'b1;
                        wr_is_sr_r <= 1'b1;
                        nv_new_r <= {sh_r[`SWP_SR_HPE], sh_r[`SWP_SR_BPHI],
                            sh_r[`SWP_SR_BPLO]};
                        twc_r <= TWC_CYC;
                    end
                end
                `SWP_OP_WRITE: begin
                    if (st_r == ST_WDATA && nbytes_r != 6'h0 && wel_r
                        && !prot_hit(bphi_r, bplo_r, addr_r[11:0])) begin
                        wip_r <= 1'b1;
                        wr_is_sr_r <= 1'b0;
                        wr_base_r <= {addr_r[11:5], 5'h00};
                        wr_idx_r <= 5'h0;
                        armed_r <= 1'b1;
                        twc_r <= TWC_CYC;
                    end
                end
                default: begin
                end
            endcase
        end
        // Timer runs on regardless of traffic, so a frame never stalls it
        if (wip_r) begin
            // Page contents go out one word per clock while the timer runs
            if (armed_r) begin
                arr_we_out <= 1'b1;
                arr_addr_out <= wr_base_r | {7'h00, wr_idx_r};
                arr_data_out <= page_r[wr_idx_r];
                wr_idx_r <= wr_idx_r + 5'h1;
                if (wr_idx_r == 5'h1f) begin
                    armed_r <= 1'b0;
                end
            end
            if (twc_r > 32'h1) begin
                twc_r <= twc_r - 32'h1;
            end else begin
                wip_r <= 1'b0;
                // A set-latch landing in the same cycle wins
                if (!(cs_rise && bit_r == 3'h0 && cmd_r == `SWP_OP_SET_LATCH
                    && st_r == ST_IGN)) begin
                    wel_r <= 1'b0;
                end
                if (wr_is_sr_r) begin
                    {hpe_r, bphi_r, bplo_r} <= nv_new_r;
                end
            end
        end
    end
end

// Registered status view
always @(posedge sys_clk_in) begin
    if (rst_in) begin
        status_out <= 8'h00;
    end else begin
        status_out <= sr_val;
    end
end

endmodule // swp_core

// ==== hw/swp_sync.v ====
`timescale 1ns/1ps
// Two flip-flop synchroniser for the serial pins
module swp_sync #(
    parameter WIDTH = 4,
    // Idle level of each pin, so reset does not fake an edge
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Asynchronous levels
    input wire [WIDTH-1:0] async_in,
    // Synchronised levels
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_r;

// First stage feeds only the second
always @(posedge sys_clk_in) begin
    if (rst_in) begin
        meta_r <= RST_VAL;
        sync_out <= RST_VAL;
    end else begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
end

endmodule // swp_sync

// ==== inc/swp_map.vh ====
`ifndef SWP_MAP_VH
`define SWP_MAP_VH
// Command opcodes
`define SWP_OP_SET_LATCH 8'h06
`define SWP_OP_CLR_LATCH 8'h04
`define SWP_OP_RD_STATUS 8'h05
`define SWP_OP_WR_STATUS 8'h01
`define SWP_OP_WRITE 8'h02
`define SWP_OP_READ 8'h03
// Status field positions
`define SWP_SR_HPE 7
`define SWP_SR_BPHI 3
`define SWP_SR_BPLO 2
`define SWP_SR_WEL 1
`define SWP_SR_WIP 0
// Protected ranges, array address bits 11:0
`define SWP_QTR_BASE 12'hc00
`define SWP_HALF_BASE 12'h800
// Nonvolatile reset contents: loaded on every reset
`define SWP_NV_RESET 3'h0
// Internal write cycle time in us and in system clocks
`define SWP_TWC_US 5000
`define SWP_CLK_MHZ 50
`define SWP_TWC_CYC (`SWP_TWC_US * `SWP_CLK_MHZ)
`endif

// ==== verif/swp_core_properties.sv ====
`timescale 1ns/1ps
module swp_core_chk #(
    parameter TWC_CYC = 600
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Pins and status
    input wire cs_n_in,
    input wire wp_n_in,
    input wire so_oe_n_out,
    input wire arr_we_out,
    input wire [11:0] arr_addr_out,
    input wire [7:0] status_out
);
    // Slack around the busy count; the page pulses run during it, not before it
    localparam int LO = TWC_CYC - 2;
    localparam int HI = TWC_CYC + 34;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    property p_undef; status_out[6:4] == 3'b000; endproperty
    a_undef: assert property (p_undef) else $error("spare bits set");
    property p_pwr; $fell(rst_in) |-> !status_out[1] && so_oe_n_out; endproperty
    a_pwr: assert property (p_pwr) else $error("bad power-on state");
    property p_launch; $rose(status_out[0]) |-> $past(status_out[1]); endproperty
    a_launch: assert property (p_launch) else $error("busy without latch");
    property p_nv;
        $changed(status_out[7:2]) |-> $past(status_out[1]) || $fell(status_out[0]);
    endproperty
    a_nv: assert property (p_nv) else $error("protect bits moved");
    property p_hwp; $changed(status_out[7:2]) |-> $past(wp_n_in, 8) || !$past(status_out[7]);
    endproperty
    a_hwp: assert property (p_hwp) else $error("write under pin protect");
    property p_wip_end; $rose(status_out[0]) |-> ##[LO:HI] $fell(status_out[0]); endproperty
    a_wip_end: assert property (p_wip_end) else $error("busy length");
    property p_wip_hold; $rose(status_out[0]) |=> status_out[0] [*8]; endproperty
    a_wip_hold: assert property (p_wip_hold) else $error("busy broken");
    property p_wel_done; $fell(status_out[0]) |-> ##[0:2] !status_out[1]; endproperty
    a_wel_done: assert property (p_wel_done) else $error("latch kept");
    property p_we_prot;
        arr_we_out |-> !(status_out[3:2] == 2'b11 || status_out[3:2] == 2'b10 && arr_addr_out[11]
            || status_out[3:2] == 2'b01 && arr_addr_out[11:10] == 2'b11);
    endproperty
    a_we_prot: assert property (p_we_prot) else $error("protected write");
    property p_idle_oe; cs_n_in [*8] |=> so_oe_n_out; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("output driven idle");
    c_wip: cover property ($rose(status_out[0]));
    c_nv: cover property ($changed(status_out[3:2]));
    c_we: cover property (arr_we_out && arr_addr_out[11]);
endmodule // swp_core_chk
bind swp_core swp_core_chk #(.TWC_CYC(TWC_CYC)) i_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .cs_n_in(cs_n_in), .wp_n_in(wp_n_in), .so_oe_n_out(so_oe_n_out), .arr_we_out(arr_we_out),
    .arr_addr_out(arr_addr_out), .status_out(status_out));

// ==== verif/swp_host_model.sv ====
`timescale 1ns/1ps
module swp_host_model (
    // Serial pins
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in
);
    // Link clock parked low between frames
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // Sends the top nb bits; rd keeps the last byte heard
    task automatic frame(input logic [31:0] v, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        cs_n_out = 1'b0;
        for (int i = 0; i < nb; i++) begin
            si_out = v[31-i];
            #80 sck_out = 1'b1;
            rd = {rd[6:0], so_in};
            #80 sck_out = 1'b0;
        end
        #80 cs_n_out = 1'b1;
        si_out = ~si_out; // No stale bit left on the line
        #400;
    endtask
endmodule // swp_host_model

// ==== verif/test_serial_eeprom_write_protect.sv ====
`timescale 1ns/1ps
`include "swp_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module test_serial_eeprom_write_protect;
    localparam int TWC = 600;
    logic sys_clk_in = 0;
    logic rst_in = 1;
    logic wp_n_in = 1;
    wire sck, cs_n, si, so, we;
    wire [7:0] st;
    int err_total = 0;
    int cmp_count = 0;
    int we_cnt = 0;
    logic [31:0] lfsr = 32'ha5ab10e9;
    logic [7:0] rd, v;
    logic [11:0] a0;
    swp_host_model i_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so));
    swp_core #(.TWC_CYC(TWC)) i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sck_in(sck),
        .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n_in), .so_out(so), .so_oe_n_out(),
        .arr_we_out(we), .arr_addr_out(), .arr_data_out(), .status_out(st));
    initial forever #10 sys_clk_in = ~sys_clk_in;
    // Page pulses counted per launch
    always @(posedge sys_clk_in) if (we === 1'b1) we_cnt++;
    function automatic int f_pulses(input logic [1:0] bp, input logic [11:0] a);
        return (bp == 3 || bp == 2 && a[11] || bp == 1 && a[11:10] == 2'b11) ? 0 : 32;
    endfunction
    task automatic fr(input logic [7:0] op, input logic [23:0] d, input int nb);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        i_host.frame({op, d}, nb, rd);
    endtask
    // Bounded wait for the write cycle to finish
    task automatic idle;
        for (int i = 0; i < TWC + 99 && st[0] !== 1'b0; i++) @(posedge sys_clk_in);
    endtask
    task automatic write_status_cmd(input logic [7:0] d);
        fr(`SWP_OP_SET_LATCH, 0, 8);
        fr(`SWP_OP_WR_STATUS, {d, 16'h0}, 16);
        idle;
    endtask
    task automatic awr(input logic [11:0] a, input int nb);
        we_cnt = 0;
        fr(`SWP_OP_WRITE, {4'h0, a, lfsr[7:0]}, nb);
    endtask
    task automatic report_and_stop;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #1500000;
        err_total++;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        `CHK(st, 8'h00)
        fr(`SWP_OP_SET_LATCH, 0, 4);
        `CHK(st[1], 1'b0)
        fr(`SWP_OP_SET_LATCH, 0, 8);
        `CHK(st[1], 1'b1)
        fr(`SWP_OP_RD_STATUS, 0, 16);
        `CHK(rd, 8'h02)
        awr(12'h040, 28);
        idle;
        `CHK(we_cnt, 0)
        fr(`SWP_OP_CLR_LATCH, 0, 8);
        `CHK(st[1], 1'b0)
        awr(12'h040, 32);
        idle;
        `CHK(we_cnt, 0)
        // Every protect pattern, random spare bits and upper-half address
        for (int k = 0; k < 4; k++) begin
            v = {lfsr[7:4], k[1:0], lfsr[1:0]};
            write_status_cmd(v);
            `CHK(st, {v[7], 3'b000, v[3:2], 2'b00})
            fr(`SWP_OP_SET_LATCH, 0, 8);
            a0 = lfsr[11:0] | 12'h800;
            awr(a0, 32);
            idle;
            `CHK(we_cnt, f_pulses(v[3:2], a0))
            fr(`SWP_OP_CLR_LATCH, 0, 8);
        end
        write_status_cmd(8'h80);
        @(posedge sys_clk_in);
        wp_n_in <= 1'b0;
        write_status_cmd(8'h0c);
        `CHK(st, 8'h82)
        fr(`SWP_OP_CLR_LATCH, 0, 8);
        `CHK(st, 8'h80)
        fr(`SWP_OP_SET_LATCH, 0, 8);
        awr(12'h100, 32);
        idle;
        `CHK(we_cnt, 32)
        @(posedge sys_clk_in);
        wp_n_in <= 1'b1;
        write_status_cmd(8'h00);
        `CHK(st, 8'h00)
        // Status read and a second write while busy
        fr(`SWP_OP_SET_LATCH, 0, 8);
        awr(12'h010, 32);
        fr(`SWP_OP_RD_STATUS, 0, 16);
        `CHK(rd, 8'h03)
        fr(`SWP_OP_WRITE, 24'h02055, 32);
        idle;
        `CHK(we_cnt, 32)
        `CHK(st, 8'h00)
        report_and_stop;
    end
endmodule // test_serial_eeprom_write_protect
